// >>> logic/ssrep_pkg.sv
// Constants and carrier types for the switch sideband reset and event pin logic.
// Assumes one clock of 125 MHz and an asynchronous active-low hard reset.
//
// Functional notes
// R1 - Low hard reset clears everything asynchronously.
// R2 - Board drives hard reset low at power-up.
// R3 - Interrupt pin pulled low while interrupt pending.
// R4 - Valid link reset request pulls reset pin low.
// R5 - Without self-reset, hold until software clears.
// R6 - With self-reset, hold until sequence finishes.
// R7 - Hard reset releases reset pin until request.
// R8 - Each input edge sends one broadcast event.
// R9 - Output toggles once per enabled received symbol; the code drops symbols past 63 pending toggles.
// R10 - Event pin stable ten cycles around changes.
// R11 - Management serial clock at most 100 kHz.
// R12 - Reference clock supplied at most 156.25 MHz.
// R13 - Reference clock drives serial and fabric logic.
// R14 - Register-bus clock counts pin sampling windows.
// R15 - Event input two-flop synchronised, then edge-compared.
// R16 - Event output level register resets low.
package ssrep_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int MGMT_CLK_MAX_HZ = 100_000;
    // Highest rate means shortest period, so the divider rounds up.
    localparam int MGMT_DIV_CYC = (CLK_FREQ_HZ + MGMT_CLK_MAX_HZ - 1) / MGMT_CLK_MAX_HZ;
    localparam int EVT_STABLE_CYC = 10;
    localparam int NUM_PORTS = 8;
    localparam int PEND_W = 6;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic EVT_OUT_RST = 1'b0;

    typedef enum logic [1:0] {
        SSREP_RST_IDLE,
        SSREP_RST_HELD,
        SSREP_RST_SELF
    } ssrep_rst_state_t;

    // Reset request traffic coming from the port logic and software.
    typedef struct packed {
        logic [NUM_PORTS-1:0] req_valid;
        logic self_reset_sel;
        logic sw_clear;
        logic self_reset_done;
    } ssrep_rst_req_t;

    // Multicast event symbols received by the ports.
    typedef struct packed {
        logic [NUM_PORTS-1:0] sym_rx;
        logic [NUM_PORTS-1:0] port_en;
    } ssrep_mcast_rx_t;

endpackage : ssrep_pkg

// >>> logic/ssrep_sync_edge.sv
// Two-flop synchroniser with an edge detector behind it.
// Assumes the input is a level that may change at any time.
`timescale 1ns/100ps
module ssrep_sync_edge
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in, edge out
    input wire logic din,
    output logic level,
    output logic edge_seen
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic edge_reg;
    logic edge_next;

    // The first flop feeds only the second one.
    always_comb
    begin
        edge_next = sync_reg ^ prev_reg; // see R15
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
            edge_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= din;
            sync_reg <= meta_reg; // see R15
            prev_reg <= sync_reg;
            edge_reg <= edge_next;
        end
    end

    assign level = prev_reg;
    assign edge_seen = edge_reg;

endmodule : ssrep_sync_edge

// >>> logic/ssrep_top.sv
// Sideband pins of the packet switch: soft-reset out, interrupt out,
// multicast event pin and the management serial clock rate tick.
// Assumes clk is the register-bus clock and all inputs are synchronous to it,
// except the multicast event pin, which is synchronised here.
`timescale 1ns/100ps
module ssrep_top
    import ssrep_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Interrupt
    input wire logic irq_pending,
    output logic int_pin_o,
    output logic int_pin_oe,
    // Link reset request
    input wire ssrep_pkg::ssrep_rst_req_t rst_req,
    output logic link_reset_request_out_o,
    output logic link_reset_request_out_oe,
    output logic link_reset_active,
    // Multicast event pin
    input wire logic mcast_dir_out,
    input wire ssrep_pkg::ssrep_mcast_rx_t mcast_rx,
    input wire logic multicast_event_pin_i,
    output logic multicast_event_pin_o,
    output logic multicast_event_pin_oe,
    output logic mcast_send_all,
    // Management serial clock rate
    output logic mgmt_clk_tick
);
    import ssrep_pkg::*;

    localparam logic [PEND_W-1:0] PEND_MAX = '1;
    localparam logic [3:0] STABLE_CYC = 4'(EVT_STABLE_CYC);
    localparam logic [10:0] MGMT_DIV_LAST = 11'(MGMT_DIV_CYC - 1);

    function automatic logic [PEND_W-1:0] count_ones(input logic [NUM_PORTS-1:0] v);
        logic [PEND_W-1:0] n;
        n = '0;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            n = n + PEND_W'(v[i]);
        end
        return n;
    endfunction : count_ones

    // ****************************************************************
    // Interrupt pin
    // ****************************************************************
    logic int_oe_reg;
    logic int_oe_next;

    always_comb
    begin
        int_oe_next = irq_pending; // see R3
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_oe_reg <= 1'b0; // see R1
        end
        else
        begin
            int_oe_reg <= int_oe_next;
        end
    end

    // ****************************************************************
    // Soft reset output
    // ****************************************************************
    ssrep_rst_state_t rst_state_reg;
    ssrep_rst_state_t rst_state_next;
    logic rst_oe_reg;
    logic rst_oe_next;
    logic any_req;

    // A new request in the clearing cycle keeps the pin asserted.
    always_comb
    begin
        any_req = |rst_req.req_valid; // see R4
        rst_state_next = rst_state_reg;
        unique case (rst_state_reg)
            SSREP_RST_IDLE:
            begin
                if (any_req)
                begin
                    rst_state_next = rst_req.self_reset_sel ? SSREP_RST_SELF : SSREP_RST_HELD;
                end
            end
            SSREP_RST_HELD:
            begin
                if (rst_req.sw_clear && !any_req)
                begin
                    rst_state_next = SSREP_RST_IDLE; // see R5
                end
            end
            SSREP_RST_SELF:
            begin
                if (rst_req.self_reset_done && !any_req)
                begin
                    rst_state_next = SSREP_RST_IDLE; // see R6
                end
            end
            default:
            begin
                rst_state_next = SSREP_RST_IDLE;
            end
        endcase
        rst_oe_next = (rst_state_next != SSREP_RST_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_state_reg <= SSREP_RST_IDLE; // see R7
            rst_oe_reg <= 1'b0; // see R7
        end
        else
        begin
            rst_state_reg <= rst_state_next;
            rst_oe_reg <= rst_oe_next;
        end
    end

    // ****************************************************************
    // Multicast event pin
    // ****************************************************************
    logic pin_edge;

    ssrep_sync_edge u_event_sync
    (
        .clk(clk), // see R14
        .rst_n(rst_n),
        .din(multicast_event_pin_i),
        .level(),
        .edge_seen(pin_edge)
    );

    logic send_reg;
    logic send_next;
    logic mout_reg;
    logic mout_next;
    logic moe_reg;
    logic moe_next;
    logic [PEND_W-1:0] pend_reg;
    logic [PEND_W-1:0] pend_next;
    logic [3:0] stable_reg;
    logic [3:0] stable_next;
    logic [PEND_W-1:0] arrivals;
    logic do_toggle;

    // Toggles are queued so that bursts of symbols keep the pin stable long
    // enough to be seen; a queue overflow saturates and loses the excess.
    always_comb
    begin
        arrivals = count_ones(mcast_rx.sym_rx & mcast_rx.port_en); // see R9 R13
        do_toggle = mcast_dir_out && (pend_reg != '0) && (stable_reg >= STABLE_CYC); // see R10
        send_next = !mcast_dir_out && pin_edge; // see R8
        moe_next = mcast_dir_out;
        mout_next = do_toggle ? !mout_reg : mout_reg; // see R16
        pend_next = pend_reg;
        if (mcast_dir_out)
        begin
            if (PEND_W'(PEND_MAX - pend_reg) < arrivals)
            begin
                pend_next = PEND_MAX;
            end
            else
            begin
                pend_next = pend_reg + arrivals;
            end
            if (do_toggle && pend_next != '0)
            begin
                pend_next = pend_next - PEND_W'(1);
            end
        end
        else
        begin
            pend_next = '0;
        end
        // Stability is counted in both directions, also across a direction change.
        if (do_toggle || (!mcast_dir_out && pin_edge))
        begin
            stable_next = 4'h0; // see R10
        end
        else if (stable_reg < STABLE_CYC) // see R14
        begin
            stable_next = stable_reg + 4'h1;
        end
        else
        begin
            stable_next = stable_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            send_reg <= 1'b0;
            mout_reg <= EVT_OUT_RST; // see R16
            moe_reg <= 1'b0;
            pend_reg <= '0;
            stable_reg <= 4'h0;
        end
        else
        begin
            send_reg <= send_next;
            mout_reg <= mout_next;
            moe_reg <= moe_next;
            pend_reg <= pend_next;
            stable_reg <= stable_next;
        end
    end

    // ****************************************************************
    // Management serial clock rate tick
    // ****************************************************************
    logic [10:0] div_reg;
    logic [10:0] div_next;
    logic tick_reg;
    logic tick_next;

    always_comb
    begin
        tick_next = (div_reg == MGMT_DIV_LAST); // see R11
        div_next = tick_next ? 11'h000 : div_reg + 11'h001;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= 11'h000;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // ****************************************************************
    // Outputs, all from flops
    // ****************************************************************
    logic zero_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_reg <= 1'b0;
        end
        else
        begin
            zero_reg <= 1'b0;
        end
    end

    assign int_pin_o = zero_reg;
    assign int_pin_oe = int_oe_reg;
    assign link_reset_request_out_o = zero_reg;
    assign link_reset_request_out_oe = rst_oe_reg;
    assign link_reset_active = rst_oe_reg;
    assign multicast_event_pin_o = mout_reg;
    assign multicast_event_pin_oe = moe_reg;
    assign mcast_send_all = send_reg;
    assign mgmt_clk_tick = tick_reg;

endmodule : ssrep_top

// >>> tb/ssrep_properties.sv
// Checker for the sideband pin logic, bound to ssrep_top.
// Assumes one clock domain with the asynchronous active-low hard reset.
`timescale 1ns/100ps
module ssrep_properties
    import ssrep_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic irq_pending,
    input wire logic int_pin_o,
    input wire logic int_pin_oe,
    input wire ssrep_pkg::ssrep_rst_req_t rst_req,
    input wire logic link_reset_request_out_o,
    input wire logic link_reset_request_out_oe,
    input wire logic link_reset_active,
    input wire logic mcast_dir_out,
    input wire logic multicast_event_pin_i,
    input wire logic multicast_event_pin_o,
    input wire logic mcast_send_all
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic prev_o;
    logic [7:0] stable_cnt;
    // Cycles since the driven event level last changed, saturating.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_o <= 1'b0;
            stable_cnt <= 8'h00;
        end
        else
        begin
            prev_o <= multicast_event_pin_o;
            if (multicast_event_pin_o != prev_o)
                stable_cnt <= 8'h00;
            else
                stable_cnt <= stable_cnt + {7'h00, stable_cnt != 8'hff};
        end
    end
    sequence s_pin_edge;
        !mcast_dir_out && $changed(multicast_event_pin_i);
    endsequence
    sequence s_send;
        ##[2:5] mcast_send_all;
    endsequence
    sequence s_rst_held;
        link_reset_request_out_oe && !rst_req.sw_clear && !rst_req.self_reset_done;
    endsequence
    int_follow_a: assert property (irq_pending |=> int_pin_oe)
        else $error("interrupt pin not pulled while pending");
    int_release_a: assert property (!irq_pending |=> !int_pin_oe)
        else $error("interrupt pin pulled with nothing pending");
    od_low_a: assert property (!int_pin_o && !link_reset_request_out_o)
        else $error("open-drain output driven high");
    rst_set_a: assert property (|rst_req.req_valid |=> link_reset_request_out_oe)
        else $error("reset output not asserted after request");
    rst_hold_a: assert property (s_rst_held |=> link_reset_request_out_oe)
        else $error("reset output released without clear or done");
    rst_quiet_a: assert property (!link_reset_request_out_oe && !(|rst_req.req_valid) |=>
        !link_reset_request_out_oe)
        else $error("reset output asserted without request");
    rst_active_a: assert property (link_reset_active == link_reset_request_out_oe)
        else $error("reset active flag disagrees with pin");
    hard_rst_a: assert property (disable iff (1'b0) !rst_n |->
        !link_reset_request_out_oe && !multicast_event_pin_o && !mcast_send_all)
        else $error("outputs not cleared during hard reset");
    send_edge_a: assert property (s_pin_edge |-> s_send)
        else $error("event pin edge sent no broadcast");
    send_once_a: assert property (mcast_send_all |=> !mcast_send_all)
        else $error("broadcast strobe longer than one cycle");
    out_space_a: assert property ($changed(multicast_event_pin_o) |-> stable_cnt >= 8'h0a)
        else $error("event output toggled too soon");
endmodule : ssrep_properties

bind ssrep_top ssrep_properties u_props (.clk(clk), .rst_n(rst_n),
    .irq_pending(irq_pending), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
    .rst_req(rst_req), .link_reset_request_out_o(link_reset_request_out_o),
    .link_reset_request_out_oe(link_reset_request_out_oe),
    .link_reset_active(link_reset_active), .mcast_dir_out(mcast_dir_out),
    .multicast_event_pin_i(multicast_event_pin_i),
    .multicast_event_pin_o(multicast_event_pin_o), .mcast_send_all(mcast_send_all));

// >>> tb/ssrep_board_model.sv
// Board model: power-up reset source and peer logic at the event pin.
// Assumes the event pin has a pull-down and nobody else drives it.
`timescale 1ns/100ps
module ssrep_board_model
    import ssrep_pkg::*;
(
    // Clock
    input wire logic clk,
    // Device side of the event pin
    input wire logic dut_o,
    input wire logic dut_oe,
    // Board outputs
    output logic rst_n,
    output logic pin_level
);
    logic drv_oe = 1'b0;
    logic drv_lvl = 1'b0;
    // The pull-down sets the level when nobody drives the pin.
    assign pin_level = dut_oe ? dut_o : (drv_oe ? drv_lvl : 1'b0);
    initial rst_n = 1'b0;
    // The device has no supply detector, so reset starts low.
    task automatic power_up(input int cyc);
        repeat (cyc) @(posedge clk);
        rst_n <= 1'b1;
    endtask : power_up
    task automatic drop_reset();
        #2 rst_n = 1'b0;
    endtask : drop_reset
    // Level is held stable before and after each change.
    task automatic toggle_pin();
        repeat (EVT_STABLE_CYC + 1) @(posedge clk);
        drv_lvl <= drv_oe ? ~drv_lvl : 1'b1;
        drv_oe <= 1'b1;
        repeat (EVT_STABLE_CYC + 1) @(posedge clk);
    endtask : toggle_pin
    task automatic release_pin();
        @(posedge clk);
        drv_oe <= 1'b0;
    endtask : release_pin
endmodule : ssrep_board_model

// >>> tb/tb_ssrep_top.sv
// Self-checking bench for the sideband reset and event pin logic.
// Assumes the board model supplies hard reset and far-side event traffic.
`timescale 1ns/100ps
module tb_ssrep_top;
    import ssrep_pkg::*;
    logic clk = 1'b0;
    logic irq_pending = 1'b0;
    logic mcast_dir_out = 1'b0;
    ssrep_rst_req_t rst_req = '0;
    ssrep_mcast_rx_t mcast_rx = '0;
    logic rst_n, pin_level, int_pin_o, int_pin_oe, lr_o, lr_oe, lr_act;
    logic ev_o, ev_oe, send_all, tick, prev_pin;
    int n_fail = 0, num_checks = 0, cyc = 0, n_send = 0, n_tog = 0;
    ssrep_board_model u_board (.clk(clk), .dut_o(ev_o), .dut_oe(ev_oe), .rst_n(rst_n),
        .pin_level(pin_level));
    ssrep_top u_dut (.clk(clk), .rst_n(rst_n), .irq_pending(irq_pending),
        .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .rst_req(rst_req),
        .link_reset_request_out_o(lr_o), .link_reset_request_out_oe(lr_oe),
        .link_reset_active(lr_act), .mcast_dir_out(mcast_dir_out), .mcast_rx(mcast_rx),
        .multicast_event_pin_i(pin_level), .multicast_event_pin_o(ev_o),
        .multicast_event_pin_oe(ev_oe), .mcast_send_all(send_all), .mgmt_clk_tick(tick));
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        n_send += (send_all === 1'b1);
        n_tog += (pin_level !== prev_pin);
        prev_pin = pin_level;
        if (cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic t_irq();
        @(posedge clk) irq_pending <= 1'b1;
        wait_cyc(2);
        chk("int_pin_oe", 16'h1, int_pin_oe);
        chk("int_pin_o", 16'h0, int_pin_o);
        @(posedge clk) irq_pending <= 1'b0;
        wait_cyc(2);
        chk("int_pin_oe", 16'h0, int_pin_oe);
    endtask : t_irq
    // The wrong finishing event is sent first and must be ignored.
    task automatic t_reset_req(input logic sel);
        @(posedge clk);
        rst_req.req_valid <= 8'h04;
        rst_req.self_reset_sel <= sel;
        @(posedge clk) rst_req.req_valid <= 8'h00;
        wait_cyc(1);
        chk("reset oe", 16'h1, lr_oe);
        chk("reset level", 16'h0, lr_o);
        chk("reset active", 16'h1, lr_act);
        @(posedge clk) {rst_req.sw_clear, rst_req.self_reset_done} <= sel ? 2'h2 : 2'h1;
        @(posedge clk) {rst_req.sw_clear, rst_req.self_reset_done} <= 2'h0;
        wait_cyc(4);
        chk("reset oe held", 16'h1, lr_oe);
        @(posedge clk) {rst_req.sw_clear, rst_req.self_reset_done} <= sel ? 2'h1 : 2'h2;
        @(posedge clk) {rst_req.sw_clear, rst_req.self_reset_done} <= 2'h0;
        wait_cyc(2);
        chk("reset oe released", 16'h0, lr_oe);
    endtask : t_reset_req
    task automatic t_hard_reset();
        @(posedge clk) rst_req.req_valid <= 8'h81;
        @(posedge clk) rst_req.req_valid <= 8'h00;
        wait_cyc(2);
        u_board.drop_reset();
        #1 chk("reset oe in hard reset", 16'h0, lr_oe);
        u_board.power_up(16);
        wait_cyc(20);
        chk("reset oe after hard reset", 16'h0, lr_oe);
    endtask : t_hard_reset
    task automatic t_event_in();
        int base;
        base = n_send;
        u_board.toggle_pin();
        u_board.toggle_pin();
        u_board.release_pin();
        wait_cyc(12);
        chk("broadcast count", 16'h2, 16'(n_send - base));
    endtask : t_event_in
    // Port 4 is not enabled, so its symbol must not toggle the pin.
    task automatic t_event_out();
        int base;
        @(posedge clk);
        mcast_dir_out <= 1'b1;
        mcast_rx.port_en <= 8'h05;
        wait_cyc(12);
        base = n_tog;
        @(posedge clk) mcast_rx.sym_rx <= 8'h0f;
        @(posedge clk) mcast_rx.sym_rx <= 8'h10;
        @(posedge clk) mcast_rx.sym_rx <= 8'h00;
        wait_cyc(40);
        chk("event toggles", 16'h2, 16'(n_tog - base));
        chk("event oe", 16'h1, ev_oe);
        chk("event level", 16'h0, pin_level);
        @(posedge clk) mcast_dir_out <= 1'b0;
    endtask : t_event_out
    task automatic t_tick();
        int n_seen, t0, gap, k;
        n_seen = 0;
        gap = 0;
        t0 = 0;
        for (k = 0; k < 3000 && n_seen < 2; k++)
        begin
            wait_cyc(1);
            if (tick === 1'b1)
            begin
                n_seen++;
                gap = k - t0;
                t0 = k;
            end
        end
        chk("tick count", 16'h2, 16'(n_seen));
        chk("tick period", 16'(125_000_000 / 100_000), 16'(gap));
    endtask : t_tick
    initial
    begin
        u_board.power_up(16);
        wait_cyc(2);
        t_irq();
        t_reset_req(1'b0);
        t_reset_req(1'b1);
        t_hard_reset();
        t_event_in();
        t_event_out();
        t_tick();
        stop_test();
    end
endmodule : tb_ssrep_top
